// *** mtdw_defines.svh ***
// Purpose: Offsets, reset values, mode codes and timing figures of the modem timing bank
// Assumes: Register indices are word indices; byte address is four times the index
// Notes: Timing figures are in their own unit; cycle counts are derived here from MTDW_CLK_NS
`ifndef MTDW_DEFINES_SVH
`define MTDW_DEFINES_SVH

// ****************************************
// Register indices
// ****************************************
`define MTDW_IDX_CRT 8'h37
`define MTDW_IDX_CWT 8'h39
`define MTDW_IDX_ATD 8'h3a
`define MTDW_IDX_RPM 8'h3b
`define MTDW_IDX_CALLER_ID_SETTINGS 8'h3c
`define MTDW_IDX_RC 8'h62
`define MTDW_IDX_IST 8'h82
`define MTDW_IDX_LVS 8'hdb
`define MTDW_IDX_GAIN_SELECT_BITS 8'hdf
`define MTDW_IDX_CF1 8'he0
`define MTDW_IDX_GENERAL_PIN_CTRL_1 8'he1
`define MTDW_IDX_GENERAL_PIN_CTRL_2 8'he2
`define MTDW_IDX_GPD 8'he3
`define MTDW_IDX_CF5 8'he4
`define MTDW_IDX_WIN_LO 8'he5
`define MTDW_IDX_WIN_HI 8'he6
`define MTDW_IDX_MODE 8'he8

// ****************************************
// Reset values
// ****************************************
`define MTDW_RST_CRT 8'h20
`define MTDW_RST_CWT 8'h3c
`define MTDW_RST_ATD 8'h29
`define MTDW_RST_RPM 8'h03
`define MTDW_RST_CALLER_ID_SETTINGS 8'h01
`define MTDW_RST_RC 8'h41
`define MTDW_RST_IST 8'h08
`define MTDW_RST_GAIN_SELECT_BITS 8'h0c
`define MTDW_RST_CF1 8'h22
`define MTDW_RST_GENERAL_PIN_CTRL_1 8'h04
`define MTDW_RST_ZERO 8'h00

// ****************************************
// Window modes and limits
// ****************************************
`define MTDW_MODE_ADDR 8'h00
`define MTDW_MODE_DATA 8'h01
`define MTDW_MODE_CTRL 8'h02
`define MTDW_LV_MIN_V 8'h03
`define MTDW_RESP_OKAY 2'b00
`define MTDW_RESP_DECERR 2'b11

// ****************************************
// Timing
// ****************************************
`define MTDW_CLK_NS 25
`define MTDW_CR_STEP_NUM_NS 5000000
`define MTDW_CR_STEP_DEN 3
`define MTDW_CW_STEP_MS 1000
`define MTDW_AT_STEP_US 53330
`define MTDW_CR_STEP_CYC ((`MTDW_CR_STEP_NUM_NS + `MTDW_CR_STEP_DEN * `MTDW_CLK_NS - 1) / (`MTDW_CR_STEP_DEN * `MTDW_CLK_NS))
`define MTDW_CW_STEP_CYC ((`MTDW_CW_STEP_MS * 1000000) / `MTDW_CLK_NS)
`define MTDW_AT_STEP_CYC ((`MTDW_AT_STEP_US * 1000) / `MTDW_CLK_NS)

`endif

// *** mtdw_pkg.sv ***
// Purpose: Types of the modem timing bank
// Assumes: Nothing beyond the defines header
// Notes: Window definition selected by the mode register
package mtdw_pkg;

  // ****************************************
  // Window definitions
  // ****************************************
  typedef enum logic [1:0] {
    MTDW_WIN_ADDR = 2'b00,
    MTDW_WIN_DATA = 2'b01,
    MTDW_WIN_CTRL = 2'b10,
    MTDW_WIN_NONE = 2'b11
  } mtdw_win_t;

endpackage

// *** mtdw_regs.sv ***
// Purpose: Modem call timing register bank with DSP window, AXI4-Lite slave
// Assumes: Line inputs synchronous to clk; ce low freezes all state
// Notes: Byte address of a register is four times its index
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "mtdw_defines.svh"

module mtdw_regs #(
  parameter int AW = 12,
  parameter int CR_STEP_CYC = `MTDW_CR_STEP_CYC,
  parameter int CW_STEP_CYC = `MTDW_CW_STEP_CYC,
  parameter int AT_STEP_CYC = `MTDW_AT_STEP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic carrier_in,
  input wire logic call_wait,
  input wire logic off_hook_answer,
  input wire logic ring_pulse,
  input wire logic ring_burst_end,
  input wire logic [7:0] line_voltage_raw,
  input wire logic [7:0] dsp_status,
  output logic carrier_valid,
  output logic call_abort,
  output logic answer_tone_start,
  output logic ring_accept,
  output logic [15:0] dsp_addr,
  output logic [13:0] dsp_data,
  output logic dsp_data_wr,
  output logic [7:0] dsp_control,
  output logic [7:0] dsp_control_2
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic step_tick(input logic [31:0] pre, input int lim);
    step_tick = (pre == 32'(lim - 1));
  endfunction

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == 8'hff) ? v : v + 8'h01;
  endfunction

  function automatic mtdw_pkg::mtdw_win_t win_of(input logic [7:0] mode);
    case (mode)
      `MTDW_MODE_ADDR: win_of = mtdw_pkg::MTDW_WIN_ADDR;
      `MTDW_MODE_DATA: win_of = mtdw_pkg::MTDW_WIN_DATA;
      `MTDW_MODE_CTRL: win_of = mtdw_pkg::MTDW_WIN_CTRL;
      default: win_of = mtdw_pkg::MTDW_WIN_NONE;
    endcase
  endfunction

  function automatic logic [3:0] misc_slot(input logic [7:0] idx);
    case (idx)
      `MTDW_IDX_CALLER_ID_SETTINGS: misc_slot = 4'h0;
      `MTDW_IDX_RC: misc_slot = 4'h1;
      `MTDW_IDX_IST: misc_slot = 4'h2;
      `MTDW_IDX_GAIN_SELECT_BITS: misc_slot = 4'h3;
      `MTDW_IDX_CF1: misc_slot = 4'h4;
      `MTDW_IDX_GENERAL_PIN_CTRL_1: misc_slot = 4'h5;
      `MTDW_IDX_GENERAL_PIN_CTRL_2: misc_slot = 4'h6;
      `MTDW_IDX_GPD: misc_slot = 4'h7;
      `MTDW_IDX_CF5: misc_slot = 4'h8;
      default: misc_slot = 4'hf;
    endcase
  endfunction

  function automatic logic [7:0] misc_rst(input int slot);
    case (slot)
      0: misc_rst = `MTDW_RST_CALLER_ID_SETTINGS;
      1: misc_rst = `MTDW_RST_RC;
      2: misc_rst = `MTDW_RST_IST;
      3: misc_rst = `MTDW_RST_GAIN_SELECT_BITS;
      4: misc_rst = `MTDW_RST_CF1;
      5: misc_rst = `MTDW_RST_GENERAL_PIN_CTRL_1;
      default: misc_rst = `MTDW_RST_ZERO;
    endcase
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] carrier_return_time_r;
  logic [7:0] carrier_wait_timeout_r;
  logic [7:0] answer_tone_delay_r;
  logic [7:0] ring_pulse_minimum_r;
  logic [7:0] dsp_window_mode_r;
  logic [7:0] line_voltage_status_r;
  logic [7:0] misc_r [0:8];
  logic [AW-1:0] aw_addr_r;
  logic aw_got_r;
  logic w_got_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_fire;
  logic [7:0] wr_idx;
  logic wr_ok;
  logic ar_fire;
  logic [7:0] ar_idx;
  logic [31:0] rd_val;
  logic rd_ok;
  mtdw_pkg::mtdw_win_t win;
  logic [7:0] lv_mag;

  assign win = win_of(dsp_window_mode_r);
  assign wr_idx = aw_addr_r[9:2];
  assign wr_ok = (aw_addr_r[AW-1:10] == '0);
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
  assign ar_idx = s_axi_araddr[9:2];
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  // ****************************************
  // AXI4-Lite write channels
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MTDW_RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_got_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_ok && rd_ok_w(wr_idx)) ? `MTDW_RESP_OKAY : `MTDW_RESP_DECERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic rd_ok_w(input logic [7:0] idx);
    rd_ok_w = (misc_slot(idx) != 4'hf) || (idx == `MTDW_IDX_CRT) || (idx == `MTDW_IDX_CWT)
      || (idx == `MTDW_IDX_ATD) || (idx == `MTDW_IDX_RPM) || (idx == `MTDW_IDX_LVS)
      || (idx == `MTDW_IDX_WIN_LO) || (idx == `MTDW_IDX_WIN_HI) || (idx == `MTDW_IDX_MODE);
  endfunction

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      carrier_return_time_r <= `MTDW_RST_CRT;
      carrier_wait_timeout_r <= `MTDW_RST_CWT;
      answer_tone_delay_r <= `MTDW_RST_ATD;
      ring_pulse_minimum_r <= `MTDW_RST_RPM;
      dsp_window_mode_r <= `MTDW_RST_ZERO;
      for (int i = 0; i < 9; i++)
      begin
        misc_r[i] <= misc_rst(i);
      end
    end
    else if (ce && wr_fire && wr_ok && w_strb_r[0])
    begin
      case (wr_idx)
        `MTDW_IDX_CRT: carrier_return_time_r <= w_data_r[7:0];
        `MTDW_IDX_CWT: carrier_wait_timeout_r <= w_data_r[7:0];
        `MTDW_IDX_ATD: answer_tone_delay_r <= w_data_r[7:0];
        `MTDW_IDX_RPM: ring_pulse_minimum_r <= w_data_r[7:0];
        `MTDW_IDX_MODE: dsp_window_mode_r <= w_data_r[7:0];
        default:
        begin
          if (misc_slot(wr_idx) != 4'hf)
          begin
            misc_r[misc_slot(wr_idx)] <= w_data_r[7:0];
          end
        end
      endcase
    end
  end

  // ****************************************
  // Window writes
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dsp_addr <= 16'h0000;
      dsp_data <= 14'h0000;
      dsp_data_wr <= 1'b0;
      dsp_control <= `MTDW_RST_ZERO;
      dsp_control_2 <= `MTDW_RST_ZERO;
    end
    else if (ce)
    begin
      dsp_data_wr <= 1'b0;
      if (wr_fire && wr_ok && w_strb_r[0])
      begin
        case (win)
          mtdw_pkg::MTDW_WIN_ADDR:
          begin
            if (wr_idx == `MTDW_IDX_WIN_LO) dsp_addr[7:0] <= w_data_r[7:0];
            if (wr_idx == `MTDW_IDX_WIN_HI) dsp_addr[15:8] <= w_data_r[7:0];
          end
          mtdw_pkg::MTDW_WIN_DATA:
          begin
            if (wr_idx == `MTDW_IDX_WIN_LO) dsp_data[7:0] <= w_data_r[7:0];
            if (wr_idx == `MTDW_IDX_WIN_HI)
            begin
              dsp_data[13:8] <= w_data_r[5:0];
              dsp_data_wr <= 1'b1;
            end
          end
          mtdw_pkg::MTDW_WIN_CTRL:
          begin
            if (wr_idx == `MTDW_IDX_WIN_LO) dsp_control <= w_data_r[7:0];
            if (wr_idx == `MTDW_IDX_WIN_HI) dsp_control_2 <= w_data_r[7:0];
          end
          default:
          begin
            dsp_data_wr <= 1'b0;
          end
        endcase
      end
    end
  end

  a_win_addr_lo: assert property (@(posedge clk) disable iff (rst)
    (ce && wr_fire && wr_ok && w_strb_r[0] && wr_idx == `MTDW_IDX_WIN_LO
      && dsp_window_mode_r == `MTDW_MODE_ADDR) |=> dsp_addr[7:0] == $past(w_data_r[7:0]))
    else $error("window address low byte not stored");
  a_win_mode_sel: assert property (@(posedge clk) disable iff (rst)
    (ce && wr_fire && wr_idx == `MTDW_IDX_WIN_HI && dsp_window_mode_r != `MTDW_MODE_DATA)
      |=> $stable(dsp_data) && !dsp_data_wr)
    else $error("data latch moved outside data mode");

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  always_comb
  begin
    rd_val = 32'h0;
    rd_ok = (s_axi_araddr[AW-1:10] == '0) && rd_ok_w(ar_idx);
    case (ar_idx)
      `MTDW_IDX_CRT: rd_val[7:0] = carrier_return_time_r;
      `MTDW_IDX_CWT: rd_val[7:0] = carrier_wait_timeout_r;
      `MTDW_IDX_ATD: rd_val[7:0] = answer_tone_delay_r;
      `MTDW_IDX_RPM: rd_val[7:0] = ring_pulse_minimum_r;
      `MTDW_IDX_LVS: rd_val[7:0] = line_voltage_status_r;
      `MTDW_IDX_MODE: rd_val[7:0] = dsp_window_mode_r;
      `MTDW_IDX_WIN_LO: rd_val[7:0] = (win == mtdw_pkg::MTDW_WIN_CTRL) ? dsp_status : 8'h00;
      `MTDW_IDX_WIN_HI: rd_val[7:0] = 8'h00;
      default:
      begin
        if (misc_slot(ar_idx) != 4'hf)
        begin
          rd_val[7:0] = misc_r[misc_slot(ar_idx)];
        end
      end
    endcase
    if (!rd_ok)
    begin
      rd_val = 32'h0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `MTDW_RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_arready <= !s_axi_rvalid && !ar_fire;
      if (ar_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? `MTDW_RESP_OKAY : `MTDW_RESP_DECERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  a_status_read: assert property (@(posedge clk) disable iff (rst)
    (ce && ar_fire && s_axi_araddr[AW-1:10] == '0 && ar_idx == `MTDW_IDX_WIN_LO
      && dsp_window_mode_r == `MTDW_MODE_CTRL) |=> s_axi_rdata == {24'h0, $past(dsp_status)})
    else $error("status window read wrong");
  a_wo_read_zero: assert property (@(posedge clk) disable iff (rst)
    (ce && ar_fire && (ar_idx == `MTDW_IDX_WIN_HI || (ar_idx == `MTDW_IDX_WIN_LO
      && dsp_window_mode_r != `MTDW_MODE_CTRL))) |=> s_axi_rdata == 32'h0)
    else $error("write-only window read nonzero");

  // ****************************************
  // Line voltage status
  // ****************************************
  assign lv_mag = line_voltage_raw[7] ? (8'h00 - line_voltage_raw) : line_voltage_raw;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      line_voltage_status_r <= `MTDW_RST_ZERO;
    end
    else if (ce)
    begin
      if (lv_mag < `MTDW_LV_MIN_V && !line_voltage_raw[7] || line_voltage_raw[7]
        && lv_mag < `MTDW_LV_MIN_V)
      begin
        line_voltage_status_r <= 8'h00;
      end
      else
      begin
        line_voltage_status_r <= line_voltage_raw;
      end
    end
  end

  a_lv_small: assert property (@(posedge clk) disable iff (rst)
    (ce && lv_mag < `MTDW_LV_MIN_V) |=> line_voltage_status_r == 8'h00)
    else $error("small line voltage not reported as zero");
  a_lv_pass: assert property (@(posedge clk) disable iff (rst)
    (ce && lv_mag >= `MTDW_LV_MIN_V) |=> line_voltage_status_r == $past(line_voltage_raw))
    else $error("line voltage not reported");

  // ****************************************
  // Carrier return qualification
  // ****************************************
  logic [31:0] cr_pre_r;
  logic [7:0] cr_steps_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cr_pre_r <= 32'h0;
      cr_steps_r <= 8'h00;
      carrier_valid <= 1'b0;
    end
    else if (ce)
    begin
      if (!carrier_in)
      begin
        cr_pre_r <= 32'h0;
        cr_steps_r <= 8'h00;
        carrier_valid <= 1'b0;
      end
      else if (!carrier_valid)
      begin
        if (cr_steps_r >= carrier_return_time_r)
        begin
          carrier_valid <= 1'b1;
        end
        else if (step_tick(cr_pre_r, CR_STEP_CYC))
        begin
          cr_pre_r <= 32'h0;
          cr_steps_r <= sat_inc(cr_steps_r);
        end
        else
        begin
          cr_pre_r <= cr_pre_r + 32'h1;
        end
      end
    end
  end

  a_carrier_early: assert property (@(posedge clk) disable iff (rst)
    (ce && !carrier_valid && cr_steps_r < carrier_return_time_r) |=> !carrier_valid)
    else $error("carrier accepted too early");
  a_carrier_drop: assert property (@(posedge clk) disable iff (rst)
    (ce && !carrier_in) |=> !carrier_valid && cr_steps_r == 8'h00)
    else $error("carrier loss not seen");

  // ****************************************
  // Carrier wait timeout
  // ****************************************
  logic [31:0] cw_pre_r;
  logic [7:0] cw_steps_r;
  logic cw_done_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cw_pre_r <= 32'h0;
      cw_steps_r <= 8'h00;
      cw_done_r <= 1'b0;
      call_abort <= 1'b0;
    end
    else if (ce)
    begin
      call_abort <= 1'b0;
      if (!call_wait || carrier_valid)
      begin
        cw_pre_r <= 32'h0;
        cw_steps_r <= 8'h00;
        cw_done_r <= 1'b0;
      end
      else if (!cw_done_r)
      begin
        if (cw_steps_r >= carrier_wait_timeout_r)
        begin
          call_abort <= 1'b1;
          cw_done_r <= 1'b1;
        end
        else if (step_tick(cw_pre_r, CW_STEP_CYC))
        begin
          cw_pre_r <= 32'h0;
          cw_steps_r <= sat_inc(cw_steps_r);
        end
        else
        begin
          cw_pre_r <= cw_pre_r + 32'h1;
        end
      end
    end
  end

  a_abort_due: assert property (@(posedge clk) disable iff (rst)
    (ce && call_wait && !carrier_valid && !cw_done_r
      && cw_steps_r >= carrier_wait_timeout_r) |=> call_abort ##1 (!call_abort || !ce))
    else $error("call abort missing or repeated");

  // ****************************************
  // Answer tone delay
  // ****************************************
  logic [31:0] at_pre_r;
  logic [7:0] at_steps_r;
  logic at_done_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      at_pre_r <= 32'h0;
      at_steps_r <= 8'h00;
      at_done_r <= 1'b0;
      answer_tone_start <= 1'b0;
    end
    else if (ce)
    begin
      answer_tone_start <= 1'b0;
      if (!off_hook_answer)
      begin
        at_pre_r <= 32'h0;
        at_steps_r <= 8'h00;
        at_done_r <= 1'b0;
      end
      else if (!at_done_r)
      begin
        if (at_steps_r >= answer_tone_delay_r)
        begin
          answer_tone_start <= 1'b1;
          at_done_r <= 1'b1;
        end
        else if (step_tick(at_pre_r, AT_STEP_CYC))
        begin
          at_pre_r <= 32'h0;
          at_steps_r <= sat_inc(at_steps_r);
        end
        else
        begin
          at_pre_r <= at_pre_r + 32'h1;
        end
      end
    end
  end

  a_tone_early: assert property (@(posedge clk) disable iff (rst)
    (ce && at_steps_r < answer_tone_delay_r) |=> !answer_tone_start)
    else $error("answer tone started too early");

  // ****************************************
  // Ring burst qualification
  // ****************************************
  logic [7:0] ring_cnt_r;
  logic [7:0] ring_eff;

  assign ring_eff = ring_pulse ? sat_inc(ring_cnt_r) : ring_cnt_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ring_cnt_r <= 8'h00;
      ring_accept <= 1'b0;
    end
    else if (ce)
    begin
      ring_accept <= 1'b0;
      if (ring_burst_end)
      begin
        ring_accept <= (ring_eff >= ring_pulse_minimum_r);
        ring_cnt_r <= 8'h00;
      end
      else
      begin
        ring_cnt_r <= ring_eff;
      end
    end
  end

  a_ring_short: assert property (@(posedge clk) disable iff (rst)
    (ce && ring_burst_end && !ring_pulse && ring_cnt_r < ring_pulse_minimum_r) |=> !ring_accept)
    else $error("short ring burst accepted");
  a_ring_ok: assert property (@(posedge clk) disable iff (rst)
    (ce && ring_burst_end && ring_cnt_r >= ring_pulse_minimum_r) |=> ring_accept)
    else $error("ring burst not accepted");

endmodule

// *** mtdw_regs_tb.sv ***
// Purpose: Self-checking bench of the modem timing register bank
// Assumes: Step parameters shortened to 4, 8 and 6 cycles
// Notes: Reads are scored by a monitor against a queue of expected words
`timescale 1ns/10ps
`include "mtdw_defines.svh"

module mtdw_regs_tb;
  localparam int CR = 4;
  localparam int CW = 8;
  localparam int AT = 6;
  logic clk, rst, awv, awr, wv, wr_y, bv, br, arv, arr, rv, rr;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0] rre, bre;
  logic dwr;
  int n_dwr = 0;
  logic carrier_in, call_wait, off_hook_answer, ring_pulse, ring_burst_end;
  logic [7:0] lv, st, dsp_control, dsp_control_2, a, b;
  logic carrier_valid, call_abort, answer_tone_start, ring_accept, r1;
  logic [15:0] dsp_addr;
  logic [13:0] dsp_data;
  logic [33:0] exp_q[$];
  int n_errors, checks_done, cycles, seed;
  mtdw_regs #(.CR_STEP_CYC(CR), .CW_STEP_CYC(CW), .AT_STEP_CYC(AT)) dut (.clk, .rst,
    .ce(1'b1), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_y), .s_axi_bresp(bre), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr), .carrier_in,
    .call_wait, .off_hook_answer, .ring_pulse, .ring_burst_end, .line_voltage_raw(lv),
    .dsp_status(st), .carrier_valid, .call_abort, .answer_tone_start, .ring_accept, .dsp_addr,
    .dsp_data, .dsp_data_wr(dwr), .dsp_control, .dsp_control_2);

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] want);
    checks_done++;
    if (seen !== want)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask

  task final_report;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    awa <= {2'b00, idx, 2'b00};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    fork
      begin
        do @(posedge clk); while (awr !== 1'b1);
        awv <= 1'b0;
      end
      begin
        do @(posedge clk); while (wr_y !== 1'b1);
        wv <= 1'b0;
      end
    join
    do @(posedge clk); while (bv !== 1'b1);
    br <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [1:0] rs, input logic [7:0] d);
    @(posedge clk);
    exp_q.push_back({rs, 24'h0, d});
    ara <= {2'b00, idx, 2'b00};
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rr <= 1'b0;
  endtask

  function automatic logic mo(input int s);
    return (s == 0) ? carrier_valid : (s == 1) ? call_abort : answer_tone_start;
  endfunction

  task automatic meas(input int sel, input int want);
    int n;
    n = 0;
    @(posedge clk);
    carrier_in <= (sel == 0);
    call_wait <= (sel == 1);
    off_hook_answer <= (sel == 2);
    do
    begin
      @(posedge clk);
      n++;
    end
    while (mo(sel) !== 1'b1 && n < want + 8);
    check("delay", 34'(n >= want - 1 && n <= want + 5), 34'h1);
    carrier_in <= 1'b0;
    call_wait <= 1'b0;
    off_hook_answer <= 1'b0;
  endtask

  task automatic ring(input int np, input logic want);
    repeat (np)
    begin
      @(posedge clk);
      ring_pulse <= 1'b1;
      @(posedge clk);
      ring_pulse <= 1'b0;
    end
    ring_burst_end <= 1'b1;
    @(posedge clk);
    ring_burst_end <= 1'b0;
    #1 r1 = ring_accept;
    @(posedge clk);
    #1 check("ring", 34'(r1 | ring_accept), 34'(want));
  endtask

  always @(posedge clk)
  begin
    if (rv === 1'b1 && rr === 1'b1)
    begin
      check("read", {rre, rdat}, exp_q.pop_front());
    end
  end

  always @(posedge clk)
  begin
    if (dwr === 1'b1)
    begin
      n_dwr <= n_dwr + 1;
    end
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      n_errors++;
      final_report;
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {rst, awv, wv, br, arv, rr, carrier_in, call_wait, off_hook_answer} = 9'h100;
    {ring_pulse, ring_burst_end, awa, ara, wd, lv, st} = '0;
    {n_errors, checks_done, cycles, seed} = {32'h0, 32'h0, 32'h0, 32'd74342};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(8'h37, 2'b00, 8'h20);
    rd(8'h39, 2'b00, 8'h3c);
    rd(8'h3a, 2'b00, 8'h29);
    rd(8'h3b, 2'b00, 8'h03);
    rd(8'he8, 2'b00, 8'h00);
    $display("test reset values done");
    meas(0, 32 * CR);
    @(posedge clk);
    #1 check("carrier drop", 34'(carrier_valid), 34'h0);
    meas(1, 60 * CW);
    meas(2, 41 * AT);
    ring(2, 1'b0);
    ring(3, 1'b1);
    $display("test timing done");
    repeat (8)
    begin
      a = 8'($random(seed));
      b = (a[0]) ? a : 8'h01 - {7'h0, a[1]} - {7'h0, a[2]};
      @(posedge clk);
      lv <= b;
      rd(8'hdb, 2'b00, (b inside {8'hfe, 8'hff, 8'h00, 8'h01, 8'h02}) ? 8'h00 : b);
    end
    $display("test line voltage done");
    for (int k = 0; k < 4; k++)
    begin
      a = 8'($random(seed));
      wr(8'h37 + 8'(k + (k > 0)), a);
      rd(8'h37 + 8'(k + (k > 0)), 2'b00, a);
    end
    wr(8'h38, a);
    check("bresp", 34'(bre), 34'h3);
    rd(8'h38, 2'b11, 8'h00);
    $display("test read write done");
    {a, b} = 16'($random(seed));
    wr(8'he8, 8'h00);
    wr(8'he5, a);
    wr(8'he6, b);
    check("addr", 34'(dsp_addr), 34'({b, a}));
    rd(8'he5, 2'b00, 8'h00);
    rd(8'he6, 2'b00, 8'h00);
    wr(8'he8, 8'h01);
    wr(8'he5, b);
    wr(8'he6, a);
    check("data", 34'(dsp_data), 34'({a[5:0], b}));
    rd(8'he5, 2'b00, 8'h00);
    wr(8'he8, 8'h02);
    st <= b;
    rd(8'he5, 2'b00, b);
    wr(8'he5, a);
    wr(8'he6, b);
    check("control", 34'({dsp_control, dsp_control_2}), 34'({a, b}));
    check("addr kept", 34'(dsp_addr), 34'({b, a}));
    @(posedge clk);
    check("data strobes", 34'(n_dwr), 34'h1);
    check("queue empty", 34'(exp_q.size()), 34'h0);
    $display("test window done");
    final_report;
  end
endmodule
